//--- rtl/wwdt_top.sv
/*
 * Windowed watchdog timer with APB register access.
 * Assumes core event inputs are one-cycle pulses synchronous to ref_clk_i,
 * and that wd_reset_o is fed to the reset controller, which answers with
 * device_reset_i.
 */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module wwdt_top
   import wwdt_pkg::*;
#(
   parameter int unsigned          OSC_DIV   = WWDT_OSC_DIV,
   parameter logic [WWDT_CFG_W-1:0] CFG_INIT = WWDT_CFG_RESET
)
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Core events
   input  wire logic        device_reset_i,
   input  wire logic        clock_switch_done_i,
   input  wire logic        clear_watchdog_instruction_i,
   input  wire logic        power_save_instruction_i,
   input  wire logic        power_save_idle_i,
   input  wire logic        wake_event_i,
   // Watchdog outputs
   output logic             wd_reset_o,
   output logic             wd_wake_o,
   output logic             low_power_rc_osc_en_o
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] closed_eighths(input logic [1:0] code);
      logic [2:0] e;
      e = 3'h2;
      unique case (code)
         2'h3: e = 3'h6;
         2'h2: e = 3'h5;
         2'h1: e = 3'h4;
         2'h0: e = 3'h2;
      endcase
      return e;
   endfunction : closed_eighths

   function automatic logic [2:0] pre_shift(input logic sel);
      return sel ? WWDT_PRE_SH_128 : WWDT_PRE_SH_32;
   endfunction : pre_shift

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WWDT_CFG_W-1:0] cfg;
      logic [15:0]           osc_cnt;
      logic [6:0]            pre_cnt;
      logic [14:0]           post_cnt;
      wwdt_pwr_t             pwr;
      logic                  soft_en;
      logic                  to_flag;
      logic                  sleep_flag;
      logic                  idle_flag;
      logic                  wd_reset;
      logic                  wake;
      logic                  osc_run;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } wwdt_state_t;

   wwdt_state_t st_ff;
   wwdt_state_t nxt_st;

   logic [1:0]  en_mode;
   logic        win_off;
   logic [2:0]  sh;
   logic [3:0]  post_sel;
   logic        in_run;
   logic        run;
   logic        tick;
   logic        pre_tick;
   logic        timeout;
   logic        win_open;
   logic        enter_ps;
   logic        leave_ps;
   logic        early;
   logic        clr_cnt;
   logic        wr;
   logic [21:0] elapsed;
   logic [22:0] period;
   logic [31:0] rd_mux;
   logic        hit;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st   = st_ff;
      en_mode  = st_ff.cfg[WWDT_CFG_EN_LSB +: 2];
      win_off  = st_ff.cfg[WWDT_CFG_WINOFF_BIT];
      sh       = pre_shift(st_ff.cfg[WWDT_CFG_PRE_BIT]);
      post_sel = st_ff.cfg[WWDT_CFG_POST_LSB +: 4];
      in_run   = (st_ff.pwr == WWDT_PWR_RUN);

      run = (en_mode == WWDT_EN_ALWAYS)
          | ((en_mode == WWDT_EN_SOFT) & st_ff.soft_en)
          | ((en_mode == WWDT_EN_ACTIVE) & (st_ff.pwr != WWDT_PWR_SLEEP));

      // Clock-enable from the divider stands in for the RC oscillator edge
      tick     = run & (st_ff.osc_cnt == 16'(OSC_DIV - 1));
      pre_tick = tick & (st_ff.pre_cnt == 7'((8'h1 << sh) - 8'h1));
      timeout  = pre_tick & (st_ff.post_cnt == 15'((16'h1 << post_sel) - 16'h1));

      // Elapsed ticks against the period, in eighths, for the window
      elapsed  = (22'(st_ff.post_cnt) << sh) | 22'(st_ff.pre_cnt);
      period   = 23'h1 << (5'(sh) + 5'(post_sel));
      win_open = (26'({elapsed, 3'h0}) >= 26'(period) * 26'(closed_eighths(st_ff.cfg[WWDT_CFG_WIN_LSB +: 2])));

      enter_ps = power_save_instruction_i & in_run;
      leave_ps = ~in_run & (wake_event_i | timeout);
      early    = clear_watchdog_instruction_i & in_run & run & ~win_off & ~win_open;

      // A stopped watchdog also drops its counts so a restart begins fresh
      clr_cnt = device_reset_i
              | clock_switch_done_i
              | enter_ps
              | leave_ps
              | (clear_watchdog_instruction_i & in_run)
              | (timeout & in_run)
              | ~run;

      if (clr_cnt)
      begin
         nxt_st.osc_cnt  = 16'h0;
         nxt_st.pre_cnt  = 7'h0;
         nxt_st.post_cnt = 15'h0;
      end
      else if (tick)
      begin
         nxt_st.osc_cnt = 16'h0;
         if (pre_tick)
         begin
            nxt_st.pre_cnt  = 7'h0;
            nxt_st.post_cnt = st_ff.post_cnt + 15'h1;
         end
         else
         begin
            nxt_st.pre_cnt = st_ff.pre_cnt + 7'h1;
         end
      end
      else
      begin
         nxt_st.osc_cnt = st_ff.osc_cnt + 16'h1;
      end

      // Power state
      unique case (st_ff.pwr)
         WWDT_PWR_RUN:
         begin
            if (enter_ps)
               nxt_st.pwr = power_save_idle_i ? WWDT_PWR_IDLE : WWDT_PWR_SLEEP;
         end
         WWDT_PWR_SLEEP, WWDT_PWR_IDLE:
         begin
            if (leave_ps)
               nxt_st.pwr = WWDT_PWR_RUN;
         end
         default:
            nxt_st.pwr = WWDT_PWR_RUN;
      endcase
      if (device_reset_i)
         nxt_st.pwr = WWDT_PWR_RUN;

      // APB: one wait-free access cycle, read data latched in setup
      hit = (paddr_i == WWDT_OFF_CFG) | (paddr_i == WWDT_OFF_RSTC) | (paddr_i == WWDT_OFF_STAT);
      rd_mux = 32'h0;
      if (paddr_i == WWDT_OFF_CFG)
         rd_mux = 32'(st_ff.cfg);
      else if (paddr_i == WWDT_OFF_RSTC)
      begin
         rd_mux[WWDT_RSTC_IDLE_BIT]  = st_ff.idle_flag;
         rd_mux[WWDT_RSTC_SLEEP_BIT] = st_ff.sleep_flag;
         rd_mux[WWDT_RSTC_TO_BIT]    = st_ff.to_flag;
         rd_mux[WWDT_RSTC_SWEN_BIT]  = st_ff.soft_en;
      end
      else if (paddr_i == WWDT_OFF_STAT)
      begin
         rd_mux[WWDT_STAT_PRE_LSB +: 7]  = st_ff.pre_cnt;
         rd_mux[WWDT_STAT_POST_LSB +: 15] = st_ff.post_cnt;
         rd_mux[WWDT_STAT_WIN_BIT]        = win_open;
         rd_mux[WWDT_STAT_PWR_LSB +: 3]   = st_ff.pwr;
      end
      nxt_st.pready = psel_i & ~penable_i;
      if (psel_i & ~penable_i)
      begin
         nxt_st.prdata  = rd_mux;
         nxt_st.pslverr = ~hit;
      end
      wr = psel_i & penable_i & st_ff.pready & pwrite_i & ~st_ff.pslverr;

      if (wr & (paddr_i == WWDT_OFF_CFG))
         nxt_st.cfg = pwdata_i[WWDT_CFG_W-1:0];
      if (wr & (paddr_i == WWDT_OFF_RSTC))
      begin
         nxt_st.idle_flag  = pwdata_i[WWDT_RSTC_IDLE_BIT];
         nxt_st.sleep_flag = pwdata_i[WWDT_RSTC_SLEEP_BIT];
         nxt_st.to_flag    = pwdata_i[WWDT_RSTC_TO_BIT];
         if (en_mode == WWDT_EN_SOFT)
            nxt_st.soft_en = pwdata_i[WWDT_RSTC_SWEN_BIT];
      end

      // Hardware sets win over a software clear in the same cycle
      if (timeout)
         nxt_st.to_flag = 1'b1;
      if (enter_ps & power_save_idle_i)
         nxt_st.idle_flag = 1'b1;
      if (enter_ps & ~power_save_idle_i)
         nxt_st.sleep_flag = 1'b1;
      if (device_reset_i | (en_mode == WWDT_EN_OFF))
         nxt_st.soft_en = 1'b0;

      nxt_st.wd_reset = (timeout & in_run) | early;
      nxt_st.wake     = timeout & ~in_run;
      nxt_st.osc_run  = run;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         st_ff     <= '0;
         st_ff.cfg <= CFG_INIT;
         st_ff.pwr <= WWDT_PWR_RUN;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign prdata_o              = st_ff.prdata;
   assign pready_o              = st_ff.pready;
   assign pslverr_o             = st_ff.pslverr;
   assign wd_reset_o            = st_ff.wd_reset;
   assign wd_wake_o             = st_ff.wake;
   assign low_power_rc_osc_en_o = st_ff.osc_run;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_setup;
      psel_i && !penable_i;
   endsequence

   sequence s_ready_pulse;
      pready_o ##1 !pready_o;
   endsequence

   a_apb_ready_one: assert property (s_setup ##1 (psel_i && penable_i) |-> pready_o ##1 !pready_o)
      else $error("access phase ready not a single pulse");
   a_apb_ready_cause: assert property (s_setup |=> s_ready_pulse or (pready_o ##1 pready_o))
      else $error("setup not answered by ready");
   a_run_timeout_rst: assert property (timeout && in_run |=> wd_reset_o && !wd_wake_o)
      else $error("timeout in run did not reset");
   a_sleep_wake: assert property (timeout && !in_run |=> wd_wake_o && st_ff.pwr == WWDT_PWR_RUN
                                  && st_ff.post_cnt == 15'h0)
      else $error("timeout in power save did not wake");
   a_flag_sticky: assert property (st_ff.to_flag && !(wr && paddr_i == WWDT_OFF_RSTC) |=> st_ff.to_flag)
      else $error("timeout flag dropped without software");
   a_flag_set: assert property (timeout |=> st_ff.to_flag)
      else $error("timeout flag not set");
   a_clear_watchdog_instruction_clear: assert property (clear_watchdog_instruction_i && in_run
                                    |=> st_ff.pre_cnt == 7'h0 && st_ff.post_cnt == 15'h0)
      else $error("clear instruction did not clear counters");
   a_early_fault: assert property (early |=> wd_reset_o ##1 !wd_reset_o || $past(timeout))
      else $error("early clear did not reset");
   a_mode_off: assert property (en_mode == WWDT_EN_OFF |=> !low_power_rc_osc_en_o && !st_ff.soft_en)
      else $error("disabled watchdog still running");
   a_mode_always: assert property (en_mode == WWDT_EN_ALWAYS |=> low_power_rc_osc_en_o)
      else $error("always-on watchdog stopped");
   a_swen_reset: assert property (device_reset_i |=> !st_ff.soft_en && st_ff.osc_cnt == 16'h0)
      else $error("device reset left watchdog state");

   sequence s_counts_zero;
      st_ff.osc_cnt == 16'h0 && st_ff.pre_cnt == 7'h0 && st_ff.post_cnt == 15'h0;
   endsequence

   a_switch_clear: assert property (clock_switch_done_i |=> s_counts_zero)
      else $error("clock switch did not clear counters");
   a_enter_clear: assert property (enter_ps |=> s_counts_zero)
      else $error("entering power save did not clear counters");
   a_enter_state: assert property (enter_ps && !device_reset_i |=> st_ff.pwr != WWDT_PWR_RUN)
      else $error("power save not entered");
   a_leave_clear: assert property (leave_ps |=> s_counts_zero)
      else $error("leaving power save did not clear counters");
   a_leave_run: assert property (leave_ps |=> st_ff.pwr == WWDT_PWR_RUN)
      else $error("power save not left");
   a_osc_follows: assert property (run |=> low_power_rc_osc_en_o)
      else $error("oscillator enable did not follow the running watchdog");
   a_soft_locked: assert property (wr && paddr_i == WWDT_OFF_RSTC && !st_ff.soft_en
                                   && en_mode != WWDT_EN_SOFT |=> !st_ff.soft_en)
      else $error("soft enable changed outside software mode");

endmodule : wwdt_top

`default_nettype wire

//--- include/wwdt_pkg.sv
/*
 * Constants for the windowed watchdog timer: register offsets, field
 * positions, reset values, enable codes and timing counts.
 * Assumes a 250 MHz system clock and a nominal 32 kHz low-power RC clock.
 */
package wwdt_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned WWDT_CLK_HZ  = 250_000_000;
   localparam int unsigned WWDT_RCOS_HZ = 32_000;
   localparam int unsigned WWDT_OSC_DIV = WWDT_CLK_HZ / WWDT_RCOS_HZ;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] WWDT_OFF_CFG  = 12'h000;
   localparam logic [11:0] WWDT_OFF_RSTC = 12'h004;
   localparam logic [11:0] WWDT_OFF_STAT = 12'h008;

   // Configuration word fields
   localparam int unsigned WWDT_CFG_POST_LSB   = 0;
   localparam int unsigned WWDT_CFG_PRE_BIT    = 4;
   localparam int unsigned WWDT_CFG_EN_LSB     = 5;
   localparam int unsigned WWDT_CFG_WINOFF_BIT = 7;
   localparam int unsigned WWDT_CFG_WIN_LSB    = 8;
   localparam int unsigned WWDT_CFG_W          = 10;
   localparam logic [9:0]  WWDT_CFG_RESET      = 10'h0df;

   // Reset-control register fields
   localparam int unsigned WWDT_RSTC_IDLE_BIT  = 2;
   localparam int unsigned WWDT_RSTC_SLEEP_BIT = 3;
   localparam int unsigned WWDT_RSTC_TO_BIT    = 4;
   localparam int unsigned WWDT_RSTC_SWEN_BIT  = 5;

   // Status register fields
   localparam int unsigned WWDT_STAT_PRE_LSB  = 0;
   localparam int unsigned WWDT_STAT_POST_LSB = 8;
   localparam int unsigned WWDT_STAT_WIN_BIT  = 24;
   localparam int unsigned WWDT_STAT_PWR_LSB  = 28;

   // Enable modes
   localparam logic [1:0] WWDT_EN_OFF    = 2'h0;
   localparam logic [1:0] WWDT_EN_ACTIVE = 2'h1;
   localparam logic [1:0] WWDT_EN_SOFT   = 2'h2;
   localparam logic [1:0] WWDT_EN_ALWAYS = 2'h3;

   // Prescaler widths as shift amounts
   localparam logic [2:0] WWDT_PRE_SH_32  = 3'h5;
   localparam logic [2:0] WWDT_PRE_SH_128 = 3'h7;

   typedef enum logic [2:0] {
      WWDT_PWR_RUN   = 3'b001,
      WWDT_PWR_SLEEP = 3'b010,
      WWDT_PWR_IDLE  = 3'b100
   } wwdt_pwr_t;

endpackage : wwdt_pkg

//--- tb/tb_wwdt_top.sv
/* Self-checking bench for the windowed watchdog: APB register tasks, event pulses, timeout timing.
   Assumes wwdt_pkg is compiled first; OSC_DIV shortened to 4 so one tick is 4 clocks. */
`timescale 1ns/100ps
`default_nettype none
module tb_wwdt_top
   import wwdt_pkg::*;
;
   localparam int DIV = 4;
   localparam int P32 = 32 * DIV;
   logic        ref_clk_i;
   logic        rst_n_i;
   logic        psel, penable, pwrite, idle, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [4:0]  evt;
   logic        pready, pslverr, wd_reset, wd_wake, osc_en;
   int          mismatches, total_checks, cyc, nrst, nwake, n, c;
   int          closed [4] = '{2, 4, 5, 6};

   wwdt_top #(.OSC_DIV(DIV)) u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .device_reset_i(evt[0]), .clock_switch_done_i(evt[1]),
      .clear_watchdog_instruction_i(evt[2]), .power_save_instruction_i(evt[3]), .power_save_idle_i(idle),
      .wake_event_i(evt[4]), .wd_reset_o(wd_reset), .wd_wake_o(wd_wake), .low_power_rc_osc_en_o(osc_en));

   // ----------------------------------------------------------------
   // Clock, hang guard, pulse counters
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   // Whole run is about 4k cycles; a hang anywhere ends here
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   // Outputs sampled mid-cycle so the count never races the edge
   always @(negedge ref_clk_i)
   begin
      if (wd_reset === 1'b1) nrst++;
      if (wd_wake === 1'b1) nwake++;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      total_checks++;
      if (got < lo || got > hi)
      begin
         mismatches++;
         $display("mismatch at %0t: %s took %0d cycles, expected %0d..%0d", $time, what, got, lo, hi);
      end
   endtask : chk_rng

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int w;
      @(posedge ref_clk_i);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      w = 0;
      // Sample pready at each rising edge; data is taken at the edge that sees it high
      do
      begin
         @(posedge ref_clk_i);
         w++;
      end
      while (pready !== 1'b1 && w < 50);
      if (w >= 50) chk(32'h0, 32'h1, "pready never came");
      q        = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic ev(input int k);
      @(posedge ref_clk_i);
      evt <= 5'h1 << k;
      @(posedge ref_clk_i);
      evt <= 5'h0;
   endtask : ev

   task automatic wait_out(input logic wake, input int max, output int cnt);
      cnt = 0;
      forever
      begin
         @(negedge ref_clk_i);
         cnt++;
         if ((wake ? wd_wake : wd_reset) === 1'b1 || cnt >= max) break;
      end
   endtask : wait_out

   function automatic logic [31:0] cf(input logic [1:0] win, input logic wd, input logic [1:0] en,
                                      input logic pre, input logic [3:0] post);
      return {22'h0, win, wd, en, pre, post};
   endfunction : cf

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; evt = 5'h0; idle = 1'b0; mismatches = 0; total_checks = 0; cyc = 0; nrst = 0; nwake = 0;
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, WWDT_OFF_CFG, 32'h0);   chk(q, 32'h0df, "cfg reset");
      apb(1'b0, WWDT_OFF_RSTC, 32'h0);  chk(q, 32'h0, "reset-control at reset");
      apb(1'b0, WWDT_OFF_STAT, 32'h0);  chk({29'h0, q[30:28]}, 32'h1, "power state after reset");
      apb(1'b1, 12'h00c, 32'h3);        chk({31'h0, last_err}, 32'h1, "unmapped write error");
      apb(1'b0, 12'h00c, 32'h0);        chk({q[30:0], last_err}, 32'h1, "unmapped read");
      chk({31'h0, osc_en}, 32'h0, "osc off, soft enable clear");
      apb(1'b1, WWDT_OFF_RSTC, 32'h20);
      // Oscillator enable follows the stored soft enable one cycle later
      repeat (2) @(negedge ref_clk_i);
      chk({31'h0, osc_en}, 32'h1, "osc on by soft enable");
      ev(0);
      apb(1'b0, WWDT_OFF_RSTC, 32'h0);  chk({31'h0, q[5]}, 32'h0, "soft enable after device reset");
      // Timeout period for prescale/postscale pairs
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, WWDT_OFF_CFG, cf(2'h0, 1'b1, WWDT_EN_ALWAYS, i == 2, 4'(i == 1)));
         ev(2);
         wait_out(1'b0, 600, n);
         c = (i == 2 ? 4 : 1) * (i == 1 ? 2 : 1) * P32;
         chk_rng(n, c - 6, c + 6, "timeout in run");
      end
      ev(2);
      apb(1'b0, WWDT_OFF_RSTC, 32'h0); chk({31'h0, q[4]}, 32'h1, "timeout flag set");
      ev(0);
      apb(1'b0, WWDT_OFF_RSTC, 32'h0); chk({31'h0, q[4]}, 32'h1, "flag survives device reset");
      apb(1'b1, WWDT_OFF_RSTC, 32'h0);
      apb(1'b0, WWDT_OFF_RSTC, 32'h0); chk({31'h0, q[4]}, 32'h0, "flag cleared by software");
      // Device reset, clock switch and clear each restart the count before it expires;
      // the first clear lands in the closed part, harmless with the window disabled
      apb(1'b1, WWDT_OFF_CFG, cf(2'h0, 1'b1, WWDT_EN_ALWAYS, 1'b0, 4'h0));
      for (int k = 0; k < 3; k++)
      begin
         c = nrst;
         ev(2);
         repeat (4)
         begin
            repeat (P32 - 28) @(posedge ref_clk_i);
            ev(k);
         end
         chk(32'(nrst - c), 32'h0, "no timeout while restarted");
      end
      // Window: early clear faults, clear after the closed part is accepted
      for (int w = 0; w < 4; w++)
      begin
         apb(1'b1, WWDT_OFF_CFG, cf(2'(w), 1'b0, WWDT_EN_ALWAYS, 1'b0, 4'h0));
         ev(2);
         repeat (closed[w] * 16 - 10) @(posedge ref_clk_i);
         ev(2);
         wait_out(1'b0, 6, n);
         chk(32'(n < 6), 32'h1, "early clear faults");
         repeat (closed[w] * 16 + 4) @(posedge ref_clk_i);
         ev(2);
         wait_out(1'b0, 6, n);
         chk(32'(n < 6), 32'h0, "clear in open window");
      end
      // Sleep then idle: timeout wakes, flag shows which
      apb(1'b1, WWDT_OFF_CFG, cf(2'h0, 1'b1, WWDT_EN_ALWAYS, 1'b0, 4'h0));
      for (int i = 0; i < 2; i++)
      begin
         idle <= 1'(i);
         c = nrst;
         ev(3);
         apb(1'b0, WWDT_OFF_STAT, 32'h0); chk({29'h0, q[30:28]}, i ? 32'h4 : 32'h2, "power state saving");
         wait_out(1'b1, 300, n);
         chk_rng(n, P32 - 14, P32 + 6, "wake by timeout");
         chk(32'(nrst - c), 32'h0, "no reset while saving");
         apb(1'b0, WWDT_OFF_RSTC, 32'h0); chk({31'h0, q[3 - i]}, 32'h1, "saving flag");
         apb(1'b1, WWDT_OFF_RSTC, 32'h0);
         apb(1'b0, WWDT_OFF_STAT, 32'h0); chk({29'h0, q[30:28]}, 32'h1, "back to run");
      end
      // Active-only mode stops in sleep; wake event restarts it
      apb(1'b1, WWDT_OFF_CFG, cf(2'h0, 1'b1, WWDT_EN_ACTIVE, 1'b0, 4'h0));
      idle <= 1'b0;
      ev(3);
      c = nwake;
      repeat (300) @(posedge ref_clk_i);
      chk(32'(nwake - c), 32'h0, "no wake in sleep, active mode");
      chk({31'h0, osc_en}, 32'h0, "osc stopped in sleep");
      ev(4);
      apb(1'b0, WWDT_OFF_STAT, 32'h0); chk({29'h0, q[30:28]}, 32'h1, "wake event to run");
      wait_out(1'b0, 300, n);
      chk_rng(n, P32 - 14, P32 + 6, "active mode timeout");
      // Disabled mode: soft enable refused, nothing runs
      apb(1'b1, WWDT_OFF_CFG, cf(2'h0, 1'b1, WWDT_EN_OFF, 1'b0, 4'h0));
      apb(1'b1, WWDT_OFF_RSTC, 32'h20);
      apb(1'b0, WWDT_OFF_RSTC, 32'h0); chk({31'h0, q[5]}, 32'h0, "soft enable refused");
      c = nrst;
      repeat (300) @(posedge ref_clk_i);
      chk({31'h0, osc_en}, 32'h0, "osc off when disabled");
      chk(32'(nrst - c), 32'h0, "no timeout when disabled");
      tally_and_finish();
   end
endmodule : tb_wwdt_top
`default_nettype wire
